//--- abe_exec.sv
`timescale 1ns/1ps
// Operation
// - Word add-immediate: pair plus constant, flags Z C N V S, two cycles.
// - Word subtract-immediate: pair minus constant, flags Z C N V S, two cycles.
// - Subtract-immediate-borrow: d minus K minus C, six flags, one cycle.
// - OR-with-constant: one cycle, Z N V S updated, C and H kept.
// - Pointer jump: PC low from Z pointer, high bits cleared, two cycles.
// - Pointer call: same target, no flags, two or three cycles by PC width.
// - Signed ge branch: N xor V zero jumps to PC+k+1, one/two cycles.
// - Signed lt branch: N xor V one jumps to PC+k+1, flags untouched.
// - Half-carry-set branch: H one jumps to PC+k+1, one/two cycles.
// - Skip-if-I/O-bit-clear: clear bit skips by two or three, 1/2/3 cycles.
// - Signed ge condition is exactly the complement of signed lt condition.
module abe_exec
  import abe_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ABE_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic ISSUE_VALID,
  input wire abe_issue_t ISSUE,
  output logic ISSUE_READY,
  output abe_wb_t WB,
  output logic DONE,
  output logic [ABE_PC_W-1:0] PC_OUT,
  output logic [7:0] FLAGS_OUT
);

  // ==========================================================
  // State
  logic [1:0] ctrl_ff;
  logic [7:0] flags_ff;
  logic [ABE_PC_W-1:0] pc_ff;
  logic busy_ff;
  logic [1:0] wait_ff;
  logic [1:0] lastcyc_ff;
  logic done_ff;
  abe_wb_t wb_ff;
  abe_wb_t pend_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic ready_ff;

  // ==========================================================
  // Operand arithmetic
  wire logic [7:0] d8 = ISSUE.src[7:0];
  wire logic [7:0] k8 = ISSUE.imm;
  wire logic cin = flags_ff[ABE_F_C];
  wire logic [16:0] kw = 17'(ISSUE.imm[ABE_WIMM_W-1:0]);
  wire logic [16:0] wadd = {1'b0, ISSUE.src} + kw;
  wire logic [16:0] wsub = {1'b0, ISSUE.src} - kw;
  wire logic [8:0] bsub = {1'b0, d8} - {1'b0, k8} - 9'(cin);
  wire logic [ABE_NIB:0] hsub = {1'b0, d8[ABE_NIB-1:0]}
                              - {1'b0, k8[ABE_NIB-1:0]} - 5'(cin);
  wire logic [7:0] orv = d8 | k8;
  wire logic s_hi = ISSUE.src[ABE_MSB16];
  wire logic d_hi = d8[ABE_MSB8];
  wire logic k_hi = k8[ABE_MSB8];

  // Word and byte overflow, sign and zero terms per operand sign and result
  wire logic wa_v = ~s_hi & wadd[ABE_MSB16];
  wire logic wa_n = wadd[ABE_MSB16];
  wire logic wa_z = (wadd[ABE_MSB16:0] == 16'h0000);
  wire logic ws_v = s_hi & ~wsub[ABE_MSB16];
  wire logic ws_n = wsub[ABE_MSB16];
  wire logic ws_z = (wsub[ABE_MSB16:0] == 16'h0000);
  wire logic bs_n = bsub[ABE_MSB8];
  wire logic bs_v = (d_hi ^ k_hi) & (d_hi ^ bs_n);
  wire logic bs_z = (bsub[ABE_MSB8:0] == 8'h00);
  wire logic or_n = orv[ABE_MSB8];
  wire logic or_z = (orv == 8'h00);

  // ==========================================================
  // Branch conditions and program counter targets
  wire logic sgn_lt = flags_ff[ABE_F_N] ^ flags_ff[ABE_F_V];
  wire logic sgn_ge = ~sgn_lt;
  wire logic [ABE_PC_W-1:0] ofs_ext =
    {{(ABE_PC_W-ABE_OFS_W){ISSUE.ofs[ABE_OFS_W-1]}}, ISSUE.ofs};
  wire logic [ABE_PC_W-1:0] pc_inc1 = pc_ff + 22'h00_0001;
  wire logic [ABE_PC_W-1:0] pc_inc2 = pc_ff + 22'h00_0002;
  wire logic [ABE_PC_W-1:0] pc_inc3 = pc_ff + 22'h00_0003;
  wire logic [ABE_PC_W-1:0] br_tgt = pc_ff + ofs_ext + 22'h00_0001;
  wire logic [ABE_PC_W-1:0] z_tgt = {{ABE_PC_HI_W{1'b0}}, ISSUE.zptr};

  // ==========================================================
  // Execute selection
  logic [7:0] nxt_flags;
  logic [ABE_PC_W-1:0] nxt_pc;
  logic [1:0] nxt_cyc;
  abe_wb_t nxt_wb;

  always_comb begin
    nxt_flags = flags_ff;
    nxt_pc = pc_inc1;
    nxt_cyc = ABE_CYC_1;
    nxt_wb = ABE_WB_RST;
    nxt_wb.idx = ISSUE.dst_idx;
    case (ISSUE.op)
      ABE_OP_WORD_ADD_IMMEDIATE: begin
        nxt_wb.we = 1'b1;
        nxt_wb.wide = 1'b1;
        nxt_wb.data = wadd[ABE_MSB16:0];
        nxt_flags[ABE_F_Z] = wa_z;
        nxt_flags[ABE_F_C] = ~wa_n & s_hi;
        nxt_flags[ABE_F_N] = wa_n;
        nxt_flags[ABE_F_V] = wa_v;
        nxt_flags[ABE_F_S] = wa_n ^ wa_v;
        nxt_cyc = ABE_CYC_2;
      end
      ABE_OP_WORD_SUBTRACT_IMMEDIATE: begin
        nxt_wb.we = 1'b1;
        nxt_wb.wide = 1'b1;
        nxt_wb.data = wsub[ABE_MSB16:0];
        nxt_flags[ABE_F_Z] = ws_z;
        nxt_flags[ABE_F_C] = ws_n & ~s_hi;
        nxt_flags[ABE_F_N] = ws_n;
        nxt_flags[ABE_F_V] = ws_v;
        nxt_flags[ABE_F_S] = ws_n ^ ws_v;
        nxt_cyc = ABE_CYC_2;
      end
      ABE_OP_SUBTRACT_IMMEDIATE_BORROW: begin
        nxt_wb.we = 1'b1;
        nxt_wb.data = {8'h00, bsub[ABE_MSB8:0]};
        nxt_flags[ABE_F_Z] = bs_z;
        nxt_flags[ABE_F_C] = bsub[ABE_MSB8+1];
        nxt_flags[ABE_F_N] = bs_n;
        nxt_flags[ABE_F_V] = bs_v;
        nxt_flags[ABE_F_S] = bs_n ^ bs_v;
        nxt_flags[ABE_F_H] = hsub[ABE_NIB];
      end
      ABE_OP_OR_WITH_CONSTANT: begin
        nxt_wb.we = 1'b1;
        nxt_wb.data = {8'h00, orv};
        nxt_flags[ABE_F_Z] = or_z;
        nxt_flags[ABE_F_N] = or_n;
        nxt_flags[ABE_F_V] = 1'b0;
        nxt_flags[ABE_F_S] = or_n;
      end
      ABE_OP_POINTER_JUMP: begin
        nxt_pc = z_tgt;
        nxt_cyc = ABE_CYC_2;
      end
      ABE_OP_POINTER_CALL: begin
        nxt_pc = z_tgt;
        // Extra cycle only for the wide program counter
        nxt_cyc = ctrl_ff[ABE_CTRL_WIDE] ? ABE_CYC_3 : ABE_CYC_2;
      end
      ABE_OP_BRANCH_SIGNED_GE: begin
        nxt_pc = sgn_ge ? br_tgt : pc_inc1;
        nxt_cyc = sgn_ge ? ABE_CYC_2 : ABE_CYC_1;
      end
      ABE_OP_BRANCH_SIGNED_LT: begin
        nxt_pc = sgn_lt ? br_tgt : pc_inc1;
        nxt_cyc = sgn_lt ? ABE_CYC_2 : ABE_CYC_1;
      end
      ABE_OP_BRANCH_HALF_CARRY_SET: begin
        nxt_pc = flags_ff[ABE_F_H] ? br_tgt : pc_inc1;
        nxt_cyc = flags_ff[ABE_F_H] ? ABE_CYC_2 : ABE_CYC_1;
      end
      ABE_OP_SKIP_IO_BIT_CLEAR: begin
        if (!ISSUE.io_bit) begin
          // Skip length follows the size of the skipped instruction
          nxt_pc = ISSUE.next_two_word ? pc_inc3 : pc_inc2;
          nxt_cyc = ISSUE.next_two_word ? ABE_CYC_3 : ABE_CYC_2;
        end
      end
      default: begin
        nxt_pc = pc_inc1;
      end
    endcase
  end

  // ==========================================================
  // Issue handshake and completion timing
  wire logic accept = ISSUE_VALID & ~busy_ff & ctrl_ff[ABE_CTRL_EN];
  wire logic single = (nxt_cyc == ABE_CYC_1);
  wire logic last = busy_ff & (wait_ff == ABE_CYC_1);

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      busy_ff <= 1'b0;
      wait_ff <= 2'h0;
      lastcyc_ff <= 2'h0;
      done_ff <= 1'b0;
      wb_ff <= ABE_WB_RST;
      pend_ff <= ABE_WB_RST;
    end else if (CE) begin
      if (accept) begin
        wait_ff <= nxt_cyc - ABE_CYC_1;
        lastcyc_ff <= nxt_cyc;
        busy_ff <= ~single;
        done_ff <= single;
        wb_ff <= single ? nxt_wb : ABE_WB_RST;
        pend_ff <= nxt_wb;
      end else if (busy_ff) begin
        wait_ff <= wait_ff - ABE_CYC_1;
        busy_ff <= ~last;
        done_ff <= last;
        wb_ff <= last ? pend_ff : ABE_WB_RST;
      end else begin
        done_ff <= 1'b0;
        wb_ff <= ABE_WB_RST;
      end
    end
  end

  // ==========================================================
  // APB slave: one wait state, registered answer
  wire logic apb_acc = PSEL & PENABLE;
  wire logic apb_fin = apb_acc & pready_ff;
  wire logic apb_wr = apb_fin & PWRITE;
  wire logic hit_ctrl = (PADDR == ABE_A_CTRL);
  wire logic hit_flags = (PADDR == ABE_A_FLAGS);
  wire logic hit_pc = (PADDR == ABE_A_PC);
  wire logic hit_stat = (PADDR == ABE_A_STAT);
  wire logic hit_any = hit_ctrl | hit_flags | hit_pc | hit_stat;
  // Write strobes fire only at the completing access edge
  wire logic wr_ctrl = apb_wr & hit_ctrl;
  wire logic wr_flags = apb_wr & hit_flags;
  wire logic wr_pc = apb_wr & hit_pc;
  wire logic [31:0] rd_mux =
    hit_ctrl ? {30'h0000_0000, ctrl_ff} :
    hit_flags ? {24'h00_0000, flags_ff} :
    hit_pc ? {10'h000, pc_ff} :
    hit_stat ? {28'h000_0000, lastcyc_ff, 1'b0, busy_ff} :
    32'h0000_0000;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (CE) begin
      pready_ff <= apb_acc & ~pready_ff;
      pslverr_ff <= apb_acc & ~pready_ff & ~hit_any;
      prdata_ff <= (apb_acc & ~pready_ff & ~PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Architectural state: execution has priority over software writes
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_ff <= ABE_CTRL_RST;
      flags_ff <= ABE_FLAGS_RST;
      pc_ff <= ABE_PC_RST;
    end else if (CE) begin
      if (wr_ctrl) begin
        ctrl_ff <= PWDATA[ABE_CTRL_WIDE:ABE_CTRL_EN];
      end
      // Hardware update wins; the software value is dropped
      if (accept) begin
        flags_ff <= nxt_flags;
        pc_ff <= nxt_pc;
      end else begin
        if (wr_flags) begin
          flags_ff <= PWDATA[ABE_MSB8:0];
        end
        if (wr_pc) begin
          pc_ff <= PWDATA[ABE_PC_W-1:0];
        end
      end
    end
  end

  // ==========================================================
  // Issue ready
  // Built from the next busy and enable values so the port comes from
  // a flop, yet it still drops in the cycle right after a multi-cycle
  // accept and rises as soon as software sets the enable bit.
  wire logic nxt_busy = accept ? ~single : (busy_ff & ~last);
  wire logic nxt_en = wr_ctrl ? PWDATA[ABE_CTRL_EN] : ctrl_ff[ABE_CTRL_EN];

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ready_ff <= 1'b0;
    end else if (CE) begin
      ready_ff <= ~nxt_busy & nxt_en;
    end
  end

  // ==========================================================
  // Outputs straight from flip-flops
  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign ISSUE_READY = ready_ff;
  assign WB = wb_ff;
  assign DONE = done_ff;
  assign PC_OUT = pc_ff;
  assign FLAGS_OUT = flags_ff;

endmodule

//--- abe_pkg.sv
package abe_pkg;

  // ==========================================================
  // Operation codes (fixed encoding shared by decode and execute)
  typedef enum logic [3:0] {
    ABE_OP_NOP = 4'h0,
    ABE_OP_WORD_ADD_IMMEDIATE = 4'h1,
    ABE_OP_WORD_SUBTRACT_IMMEDIATE = 4'h2,
    ABE_OP_SUBTRACT_IMMEDIATE_BORROW = 4'h3,
    ABE_OP_OR_WITH_CONSTANT = 4'h4,
    ABE_OP_POINTER_JUMP = 4'h5,
    ABE_OP_POINTER_CALL = 4'h6,
    ABE_OP_BRANCH_SIGNED_GE = 4'h7,
    ABE_OP_BRANCH_SIGNED_LT = 4'h8,
    ABE_OP_BRANCH_HALF_CARRY_SET = 4'h9,
    ABE_OP_SKIP_IO_BIT_CLEAR = 4'hA
  } abe_op_t;

  // ==========================================================
  // Widths and field positions
  localparam int ABE_PC_W = 22;
  localparam int ABE_PC_HI_W = 6;
  localparam int ABE_OFS_W = 12;
  localparam int ABE_WIMM_W = 6;
  localparam int ABE_MSB8 = 7;
  localparam int ABE_MSB16 = 15;
  localparam int ABE_NIB = 4;
  localparam int ABE_AW = 12;

  // Status flag bit positions
  localparam int ABE_F_C = 0;
  localparam int ABE_F_Z = 1;
  localparam int ABE_F_N = 2;
  localparam int ABE_F_V = 3;
  localparam int ABE_F_S = 4;
  localparam int ABE_F_H = 5;

  // Cycle counts
  localparam logic [1:0] ABE_CYC_1 = 2'h1;
  localparam logic [1:0] ABE_CYC_2 = 2'h2;
  localparam logic [1:0] ABE_CYC_3 = 2'h3;

  // ==========================================================
  // Register map (byte addresses) and layout
  localparam logic [ABE_AW-1:0] ABE_A_CTRL = 12'h000;
  localparam logic [ABE_AW-1:0] ABE_A_FLAGS = 12'h004;
  localparam logic [ABE_AW-1:0] ABE_A_PC = 12'h008;
  localparam logic [ABE_AW-1:0] ABE_A_STAT = 12'h00C;
  localparam int ABE_CTRL_EN = 0;
  localparam int ABE_CTRL_WIDE = 1;
  localparam logic [1:0] ABE_CTRL_RST = 2'h0;
  localparam logic [7:0] ABE_FLAGS_RST = 8'h00;
  localparam logic [ABE_PC_W-1:0] ABE_PC_RST = 22'h00_0000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    abe_op_t op;
    logic [4:0] dst_idx;
    logic [15:0] src;
    logic [7:0] imm;
    logic [ABE_OFS_W-1:0] ofs;
    logic [15:0] zptr;
    logic io_bit;
    logic next_two_word;
  } abe_issue_t;

  typedef struct packed {
    logic we;
    logic wide;
    logic [4:0] idx;
    logic [15:0] data;
  } abe_wb_t;

  localparam abe_wb_t ABE_WB_RST = '0;

endpackage

//--- abe_checker.sv
`timescale 1ns/1ps
// ==========
// Execution timing and program counter checks
module abe_checker
  import abe_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic ISSUE_VALID,
  input wire abe_issue_t ISSUE,
  input wire logic ISSUE_READY,
  input wire abe_wb_t WB,
  input wire logic DONE,
  input wire logic [ABE_PC_W-1:0] PC_OUT,
  input wire logic [7:0] FLAGS_OUT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  wire logic acc = CE && ISSUE_VALID && ISSUE_READY;
  wire logic nv = FLAGS_OUT[ABE_F_N] ^ FLAGS_OUT[ABE_F_V];
  wire logic [ABE_PC_W-1:0] tgt = PC_OUT + {{10{ISSUE.ofs[11]}}, ISSUE.ofs}
    + 22'h00_0001;
  sequence s_take(abe_op_t o);
    acc && ISSUE.op == o;
  endsequence
  sequence s_two;
    !DONE ##1 DONE;
  endsequence
  property p_add;
    s_take(ABE_OP_WORD_ADD_IMMEDIATE) |=> s_two;
  endproperty
  a_add: assert property (p_add) else $error("word add timing");
  property p_sub;
    s_take(ABE_OP_WORD_SUBTRACT_IMMEDIATE) |=> s_two;
  endproperty
  a_sub: assert property (p_sub) else $error("word sub timing");
  property p_sbc;
    s_take(ABE_OP_SUBTRACT_IMMEDIATE_BORROW) |=> DONE && WB.we;
  endproperty
  a_sbc: assert property (p_sbc) else $error("borrow sub timing");
  property p_or;
    s_take(ABE_OP_OR_WITH_CONSTANT) |=>
      FLAGS_OUT[ABE_F_C] == $past(FLAGS_OUT[ABE_F_C]) &&
      FLAGS_OUT[ABE_F_H] == $past(FLAGS_OUT[ABE_F_H]);
  endproperty
  a_or: assert property (p_or) else $error("or changed C or H");
  property p_jmp;
    s_take(ABE_OP_POINTER_JUMP) |=> PC_OUT == {6'h00, $past(ISSUE.zptr)}
      ##1 DONE;
  endproperty
  a_jmp: assert property (p_jmp) else $error("pointer jump");
  property p_call;
    s_take(ABE_OP_POINTER_CALL) |=> $stable(FLAGS_OUT) &&
      PC_OUT == {6'h00, $past(ISSUE.zptr)};
  endproperty
  a_call: assert property (p_call) else $error("pointer call");
  property p_ge;
    s_take(ABE_OP_BRANCH_SIGNED_GE) && !nv |=> PC_OUT == $past(tgt) ##1 DONE;
  endproperty
  a_ge: assert property (p_ge) else $error("ge branch");
  property p_lt;
    s_take(ABE_OP_BRANCH_SIGNED_LT) |=> $stable(FLAGS_OUT) &&
      PC_OUT == ($past(nv) ? $past(tgt) : $past(PC_OUT) + 22'h00_0001);
  endproperty
  a_lt: assert property (p_lt) else $error("lt branch");
  property p_hs;
    s_take(ABE_OP_BRANCH_HALF_CARRY_SET) && FLAGS_OUT[ABE_F_H] |=>
      PC_OUT == $past(tgt) ##1 DONE;
  endproperty
  a_hs: assert property (p_hs) else $error("half carry branch");
  property p_skip;
    s_take(ABE_OP_SKIP_IO_BIT_CLEAR) && !ISSUE.io_bit && ISSUE.next_two_word
      |=> PC_OUT == $past(PC_OUT) + 22'h00_0003 ##2 DONE;
  endproperty
  a_skip: assert property (p_skip) else $error("skip by three");
  property p_err;
    PSLVERR |-> PREADY;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
endmodule
bind abe_exec abe_checker abe_checker_i (.REF_CLK, .RST, .CE, .PREADY,
  .PSLVERR, .ISSUE_VALID, .ISSUE, .ISSUE_READY, .WB, .DONE, .PC_OUT,
  .FLAGS_OUT);

//--- abe_regfile_model.sv
`timescale 1ns/1ps
// ==========
// Register file: pair writes land in idx and idx+1
module abe_regfile_model
  import abe_pkg::*;
(
  input wire logic clk,
  input wire abe_wb_t wb,
  output logic [15:0] last
);
  logic [7:0] mem [32];
  always @(posedge clk) begin
    if (wb.we) begin
      mem[wb.idx] <= wb.data[7:0];
      if (wb.wide)
        mem[wb.idx + 5'h01] <= wb.data[15:8];
      last <= wb.data;
    end
  end
endmodule

//--- tb_alu_and_branch_execution.sv
`timescale 1ns/1ps
// ==========
// Bench
module tb_alu_and_branch_execution;
  import abe_pkg::*;
  logic clk = 0, rst = 1, ce = 1, psel = 0, pen = 0, pwr = 0, iv = 0;
  logic [ABE_AW-1:0] pa = '0;
  logic [31:0] pwd = '0, prd, rd;
  logic prdy, perr, se, irdy, done;
  abe_issue_t iss = '0;
  abe_wb_t wb;
  logic [ABE_PC_W-1:0] pc, pc0, pc1;
  logic [7:0] fl, fl0, fl1;
  logic [15:0] rfl;
  int n_errors = 0, compares = 0, cyc = 0, n;
  initial forever #20 clk = ~clk;
  abe_exec abe_exec_i (.REF_CLK(clk), .RST(rst), .CE(ce), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr), .ISSUE_VALID(iv), .ISSUE(iss),
    .ISSUE_READY(irdy), .WB(wb), .DONE(done), .PC_OUT(pc), .FLAGS_OUT(fl));
  abe_regfile_model abe_regfile_model_i (.clk(clk), .wb(wb), .last(rfl));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (!prdy);
    rd = prd;
    se = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task run(input abe_op_t op, input logic [15:0] s, input logic [7:0] k,
    input logic [11:0] o, input logic [15:0] z, input logic b, input logic t);
    @(posedge clk);
    iss <= '{op, 5'h18, s, k, o, z, b, t};
    iv <= 1;
    do @(posedge clk); while (!irdy);
    pc0 = pc;
    fl0 = fl;
    iv <= 0;
    @(negedge clk);
    pc1 = pc;
    fl1 = fl;
    n = 1;
    while (!done) begin
      @(negedge clk);
      n++;
    end
  endtask
  task t_regs;
    chk({irdy, pc, fl}, '0);
    apb(0, ABE_A_CTRL, 0);
    chk(rd, 0);
    apb(1, 12'h010, 32'h0000_00FF);
    chk({se, rd}, {1'b1, 32'h0});
    apb(1, ABE_A_FLAGS, 32'h0000_00C5);
    apb(0, ABE_A_FLAGS, 0);
    chk(rd, 32'h0000_00C5);
    apb(1, ABE_A_CTRL, 32'h0000_0001);
  endtask
  task t_word;
    apb(1, ABE_A_FLAGS, 0);
    run(ABE_OP_WORD_ADD_IMMEDIATE, 16'hFFFF, 8'h01, 0, 0, 0, 0);
    chk({n, fl1[4:0], wb.wide}, {32'h2, 5'h03, 1'b1});
    @(negedge clk);
    chk(rfl, 16'h0000);
    run(ABE_OP_WORD_SUBTRACT_IMMEDIATE, 16'h0000, 8'h01, 0, 0, 0, 0);
    @(negedge clk);
    chk({n, fl1[4:0], rfl}, {32'h2, 5'h15, 16'hFFFF});
  endtask
  task t_byte;
    apb(1, ABE_A_FLAGS, 32'h0000_0001);
    run(ABE_OP_SUBTRACT_IMMEDIATE_BORROW, 16'h0010, 8'h0F, 0, 0, 0, 0);
    chk({n, fl1[5:0], wb.data[7:0]}, {32'h1, 6'h22, 8'h00});
    apb(1, ABE_A_FLAGS, 32'h0000_0021);
    run(ABE_OP_OR_WITH_CONSTANT, 16'h0080, 8'h01, 0, 0, 0, 0);
    chk({n, fl1[5:0], wb.data[7:0]}, {32'h1, 6'h35, 8'h81});
  endtask
  task t_ptr;
    apb(1, ABE_A_PC, 32'h003F_0000);
    run(ABE_OP_POINTER_JUMP, 0, 0, 0, 16'h1234, 0, 0);
    chk({n, pc1, fl1}, {32'h2, 22'h00_1234, fl0});
    apb(1, ABE_A_CTRL, 32'h0000_0003);
    run(ABE_OP_POINTER_CALL, 0, 0, 0, 16'hBEEF, 0, 0);
    chk({n, pc1, fl1}, {32'h3, 22'h00_BEEF, fl0});
    apb(1, ABE_A_CTRL, 32'h0000_0001);
    run(ABE_OP_POINTER_CALL, 0, 0, 0, 16'h0042, 0, 0);
    chk({n, pc1, fl1}, {32'h2, 22'h00_0042, fl0});
  endtask
  task t_branch;
    abe_op_t bo [7];
    logic [7:0] bf [7];
    logic bt [7];
    bo = '{ABE_OP_BRANCH_SIGNED_GE, ABE_OP_BRANCH_SIGNED_GE,
      ABE_OP_BRANCH_SIGNED_GE, ABE_OP_BRANCH_SIGNED_LT,
      ABE_OP_BRANCH_SIGNED_LT, ABE_OP_BRANCH_HALF_CARRY_SET,
      ABE_OP_BRANCH_HALF_CARRY_SET};
    bf = '{8'h00, 8'h04, 8'h0C, 8'h08, 8'h0C, 8'h20, 8'h00};
    bt = '{1, 0, 1, 1, 0, 1, 0};
    for (int i = 0; i < 7; i++) begin
      apb(1, ABE_A_FLAGS, {24'h0, bf[i]});
      run(bo[i], 0, 0, 12'hFFE, 0, 0, 0);
      chk(pc1, bt[i] ? pc0 - 22'h1 : pc0 + 22'h1);
      chk({n, fl1}, {bt[i] ? 32'h2 : 32'h1, fl0});
    end
  endtask
  task t_skip;
    for (int i = 0; i < 3; i++) begin
      run(ABE_OP_SKIP_IO_BIT_CLEAR, 0, 0, 0, 0, i == 0, i == 2);
      chk({n, pc1, fl1}, {i + 1, pc0 + 22'(i + 1), fl0});
    end
  endtask
  task t_hold;
    pc0 = pc;
    @(posedge clk);
    ce <= 0;
    iss <= '{ABE_OP_POINTER_JUMP, 5'h18, 16'h0000, 8'h00, 12'h000, 16'h0777,
      1'b0, 1'b0};
    iv <= 1;
    repeat (4) @(posedge clk);
    chk({done, pc}, {1'b0, pc0});
    iv <= 0;
    ce <= 1;
  endtask
  task print_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard: whole run needs well under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    t_regs;
    t_word;
    t_byte;
    t_ptr;
    t_branch;
    t_skip;
    t_hold;
    print_verdict;
  end
endmodule
